// >>> design/lscp_cfg.svh
// constants of the lcd serial command port controller
`ifndef LSCP_CFG_SVH
`define LSCP_CFG_SVH

// mode identifiers, sent high bit first
`define LSCP_ID_W          3
`define LSCP_ID_CMD        3'h4
`define LSCP_ID_WRITE      3'h5
`define LSCP_ID_READ       3'h6

// frame field widths
`define LSCP_ADDR_W        6
`define LSCP_DATA_W        4
`define LSCP_CMD_W         9
`define LSCP_SHIFT_W       13

// nine-bit command codes, don't-care bits sent as zero
`define LSCP_SYSTEM_DISABLE_CMD    9'h000
`define LSCP_SYSTEM_ENABLE_CMD     9'h002
`define LSCP_DISPLAY_OFF_CMD       9'h004
`define LSCP_DISPLAY_ON_CMD        9'h006
`define LSCP_TIMEBASE_DISABLE_CMD  9'h008
`define LSCP_WATCHDOG_DISABLE_CMD  9'h00a
`define LSCP_TIMEBASE_ENABLE_CMD   9'h00c
`define LSCP_WATCHDOG_ENABLE_CMD   9'h00e
`define LSCP_TONE_OFF_CMD          9'h010
`define LSCP_TIMEBASE_CLEAR_CMD    9'h01a
`define LSCP_WATCHDOG_CLEAR_CMD    9'h01c
`define LSCP_BIAS_COM_CMD          9'h040
`define LSCP_BIAS_AB_LSB           3
`define LSCP_BIAS_C_BIT            1

// one strobe phase; covers read pulse width, cs pulse and hold times
`define LSCP_CLK_MHZ       100
`define LSCP_T_PHASE_NS    7000
`define LSCP_PHASE_CYC     ((`LSCP_T_PHASE_NS * `LSCP_CLK_MHZ + 999) / 1000)

`endif

// >>> design/lscp_pkg.sv
// types of the lcd serial command port controller
`include "lscp_cfg.svh"

package lscp_pkg;

  typedef enum logic [1:0]
  {
    LSCP_OP_CMD    = 2'h0,
    LSCP_OP_WRITE  = 2'h1,
    LSCP_OP_READ   = 2'h2,
    LSCP_OP_UPDATE = 2'h3
  } lscp_op_t;

  // gray along setup, write low/high, read low/high
  typedef enum logic [2:0]
  {
    LSCP_ST_IDLE  = 3'h0,
    LSCP_ST_SETUP = 3'h1,
    LSCP_ST_WLO   = 3'h3,
    LSCP_ST_WHI   = 3'h2,
    LSCP_ST_RLO   = 3'h6,
    LSCP_ST_RHI   = 3'h7,
    LSCP_ST_DESEL = 3'h5
  } lscp_state_t;

  typedef struct packed
  {
    lscp_state_t                 st;
    lscp_op_t                    op;
    logic [`LSCP_SHIFT_W-1:0]    sr;
    logic [3:0]                  nbits;
    logic [1:0]                  rcnt;
    logic [`LSCP_DATA_W-1:0]     rdata;
    logic [`LSCP_DATA_W-1:0]     wdata;
    logic                        wb_done;
    logic                        chain_req;
    logic                        chained;
    logic                        pending;
    logic                        sync1;
    logic                        sync2;
    logic                        cs_n;
    logic                        wr_n;
    logic                        rd_n;
    logic                        dout;
    logic                        oe_n;
    logic                        ready;
    logic                        done;
  } lscp_reg_t;

endpackage : lscp_pkg

// >>> design/lscp_tick_if.sv
// phase tick carrier between controller and its divider
`timescale 1ns/100ps
`default_nettype none

interface lscp_tick_if;
  logic clr;
  logic tick;
  modport gen  (input clr, output tick);
  modport user (output clr, input tick);
endinterface : lscp_tick_if

`default_nettype wire

// >>> design/lscp_tick_gen.sv
// divider giving one-cycle phase enable pulses
`timescale 1ns/100ps
`default_nettype none

module lscp_tick_gen #(
  parameter int unsigned PHASE_CYC = 700
) (
  input  wire logic     i_clk_sys,
  input  wire logic     i_rst_n,
  lscp_tick_if.gen      tick_if
);
  import lscp_pkg::*;

  typedef struct packed
  {
    logic [15:0] cnt;
    logic        tick;
  } lscp_div_t;

  lscp_div_t q;
  lscp_div_t d;

  always_comb
  begin
    d      = q;
    d.tick = 1'b0;
    // restart on clear; the take cycle counts, so the first phase is exactly full length
    if (tick_if.clr)
    begin
      d.cnt = 16'h0001;
    end
    else if (q.cnt >= 16'(PHASE_CYC - 1))
    begin
      d.cnt  = 16'h0000;
      d.tick = 1'b1;
    end
    else
    begin
      d.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign tick_if.tick = q.tick;

endmodule : lscp_tick_gen

`default_nettype wire

// >>> design/lscp_host.sv
// host controller driving the lcd serial command port
// How it works
// - command frames open with identifier 100
// - read frames use 110, write and update frames use 101
// - chained commands keep select low and drop the identifier
// - select high resets the port; new identifier after select falls
// - a select high pulse precedes every new identifier or mode change
// - one two-way data line carries both directions
// - read bits are sampled after read strobe rises, before it falls
// - read frame: six address bits high first, then D0 to D3 back
// - write frame: six address bits high first, then D0 to D3
// - update frame: address, nibble read back, new nibble written
`timescale 1ns/100ps
`default_nettype none
`include "lscp_cfg.svh"

module lscp_host #(
  parameter int unsigned PHASE_CYC = `LSCP_PHASE_CYC
) (
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_req_valid,
  input  wire lscp_pkg::lscp_op_t        i_req_op,
  input  wire logic [`LSCP_ADDR_W-1:0]   i_req_addr,
  input  wire logic [`LSCP_DATA_W-1:0]   i_req_data,
  input  wire logic [`LSCP_CMD_W-1:0]    i_req_cmd,
  input  wire logic                      i_req_chain,
  output var  logic                      o_req_ready,
  output var  logic                      o_rsp_valid,
  output var  logic [`LSCP_DATA_W-1:0]   o_rsp_data,
  output var  logic                      o_cs_n,
  output var  logic                      o_wr_n,
  output var  logic                      o_rd_n,
  output var  logic                      o_data_out,
  output var  logic                      o_data_oe_n,
  input  wire logic                      i_data_in
);
  import lscp_pkg::*;

  lscp_reg_t   q;
  lscp_reg_t   d;
  lscp_tick_if tick_if ();
  logic        take;

  lscp_tick_gen #(
    .PHASE_CYC (PHASE_CYC)
  ) u_tick (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .tick_if   (tick_if)
  );

  assign take        = i_req_valid & q.ready;
  assign tick_if.clr = take;

  // data bits go out D0 first
  function automatic logic [3:0] lscp_rev4(input logic [3:0] v);
    lscp_rev4 = {v[0], v[1], v[2], v[3]};
  endfunction : lscp_rev4

  always_comb
  begin
    d       = q;
    d.done  = 1'b0;
    d.sync1 = i_data_in;
    d.sync2 = q.sync1;
    case (q.st)
      LSCP_ST_IDLE:
      begin
        if (take)
        begin
          d.ready     = 1'b0;
          d.op        = i_req_op;
          d.chain_req = i_req_chain;
          d.wdata     = i_req_data;
          d.wb_done   = 1'b0;
          d.rcnt      = 2'h0;
          d.rdata     = '0;
          d.nbits     = 4'h9;
          case (i_req_op)
            LSCP_OP_CMD:    d.sr = {`LSCP_ID_CMD, i_req_cmd, 1'b0};
            LSCP_OP_WRITE:  d.sr = {`LSCP_ID_WRITE, i_req_addr, lscp_rev4(i_req_data)};
            LSCP_OP_READ:   d.sr = {`LSCP_ID_READ, i_req_addr, 4'h0};
            default:        d.sr = {`LSCP_ID_WRITE, i_req_addr, 4'h0};
          endcase
          if (i_req_op == LSCP_OP_CMD)
          begin
            d.nbits = 4'hc;
          end
          else if (i_req_op == LSCP_OP_WRITE)
          begin
            d.nbits = 4'hd;
          end
          if (q.chained && i_req_op == LSCP_OP_CMD)
          begin
            // still selected: identifier omitted, first bit goes out now
            d.sr    = {i_req_cmd, 4'h0};
            d.nbits = 4'h9;
            d.wr_n  = 1'b0;
            d.oe_n  = 1'b0;
            d.dout  = i_req_cmd[`LSCP_CMD_W-1];
            d.st    = LSCP_ST_WLO;
          end
          else if (q.chained)
          begin
            // leaving a command chain for a data mode needs a fresh select pulse
            d.cs_n    = 1'b1;
            d.pending = 1'b1;
            d.chained = 1'b0;
            d.st      = LSCP_ST_DESEL;
          end
          else
          begin
            d.cs_n = 1'b0;
            d.st   = LSCP_ST_SETUP;
          end
        end
      end
      LSCP_ST_SETUP:
      begin
        if (tick_if.tick)
        begin
          d.wr_n = 1'b0;
          d.oe_n = 1'b0;
          d.dout = q.sr[`LSCP_SHIFT_W-1];
          d.st   = LSCP_ST_WLO;
        end
      end
      LSCP_ST_WLO:
      begin
        if (tick_if.tick)
        begin
          // rising edge with data held steady through the high phase
          d.wr_n = 1'b1;
          d.st   = LSCP_ST_WHI;
        end
      end
      LSCP_ST_WHI:
      begin
        if (tick_if.tick)
        begin
          d.sr    = {q.sr[`LSCP_SHIFT_W-2:0], 1'b0};
          d.nbits = q.nbits - 4'h1;
          if (q.nbits != 4'h1)
          begin
            d.wr_n = 1'b0;
            d.dout = q.sr[`LSCP_SHIFT_W-2];
            d.st   = LSCP_ST_WLO;
          end
          else if (q.op == LSCP_OP_READ || (q.op == LSCP_OP_UPDATE && !q.wb_done))
          begin
            // let go of the line on the same edge that the read strobe falls and the device starts driving it
            d.oe_n = 1'b1;
            d.rd_n = 1'b0;
            d.st   = LSCP_ST_RLO;
          end
          else if (q.op == LSCP_OP_CMD && q.chain_req)
          begin
            d.oe_n    = 1'b1;
            d.chained = 1'b1;
            d.ready   = 1'b1;
            d.done    = 1'b1;
            d.st      = LSCP_ST_IDLE;
          end
          else
          begin
            d.oe_n    = 1'b1;
            d.cs_n    = 1'b1;
            d.chained = 1'b0;
            d.done    = 1'b1;
            d.st      = LSCP_ST_DESEL;
          end
        end
      end
      LSCP_ST_RLO:
      begin
        if (tick_if.tick)
        begin
          d.rd_n = 1'b1;
          d.st   = LSCP_ST_RHI;
        end
      end
      LSCP_ST_RHI:
      begin
        if (tick_if.tick)
        begin
          // sampled a whole phase after the rise, just before the next fall
          d.rdata[q.rcnt] = q.sync2;
          d.rcnt          = q.rcnt + 2'h1;
          if (q.rcnt != 2'h3)
          begin
            d.rd_n = 1'b0;
            d.st   = LSCP_ST_RLO;
          end
          else if (q.op == LSCP_OP_UPDATE)
          begin
            // same address, new nibble follows the one read back
            d.sr      = {lscp_rev4(q.wdata), 9'h000};
            d.nbits   = 4'h4;
            d.wb_done = 1'b1;
            d.oe_n    = 1'b0;
            d.wr_n    = 1'b0;
            d.dout    = q.wdata[0];
            d.st      = LSCP_ST_WLO;
          end
          else
          begin
            d.cs_n = 1'b1;
            d.done = 1'b1;
            d.st   = LSCP_ST_DESEL;
          end
        end
      end
      LSCP_ST_DESEL:
      begin
        // select stays high a full phase, well above the reset pulse minimum
        if (tick_if.tick)
        begin
          if (q.pending)
          begin
            d.pending = 1'b0;
            d.cs_n    = 1'b0;
            d.st      = LSCP_ST_SETUP;
          end
          else
          begin
            d.ready = 1'b1;
            d.st    = LSCP_ST_IDLE;
          end
        end
      end
      default:
      begin
        d.st = LSCP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      q       <= '0;
      q.st    <= LSCP_ST_IDLE;
      q.cs_n  <= 1'b1;
      q.wr_n  <= 1'b1;
      q.rd_n  <= 1'b1;
      q.oe_n  <= 1'b1;
      q.ready <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign o_req_ready = q.ready;
  assign o_rsp_valid = q.done;
  assign o_rsp_data  = q.rdata;
  assign o_cs_n      = q.cs_n;
  assign o_wr_n      = q.wr_n;
  assign o_rd_n      = q.rd_n;
  assign o_data_out  = q.dout;
  assign o_data_oe_n = q.oe_n;

endmodule : lscp_host

`default_nettype wire

// >>> test/lscp_host_asserts.sv
// pin-level assertions for the lcd serial command port controller
`timescale 1ns/100ps
`default_nettype none

// repetition counts below assume the bench value PHASE_CYC = 4
module lscp_host_asserts #(
  parameter int unsigned PHASE_CYC = 4
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  input  wire logic i_req_valid,
  input  wire logic o_req_ready,
  input  wire logic o_rsp_valid,
  input  wire logic o_cs_n,
  input  wire logic o_wr_n,
  input  wire logic o_rd_n,
  input  wire logic o_data_out,
  input  wire logic o_data_oe_n
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  a_strobe_excl: assert property (o_wr_n || o_rd_n)
    else $error("both strobes low");
  a_wr_selected: assert property (!o_wr_n |-> !o_cs_n)
    else $error("write strobe without select");
  a_rd_released: assert property (!o_rd_n |-> o_data_oe_n)
    else $error("data driven during read");
  a_data_on_fall: assert property ($changed(o_data_out) && !o_data_oe_n |-> $fell(o_wr_n))
    else $error("data moved off strobe fall");
  a_wr_low_phase: assert property ($fell(o_wr_n) |-> !o_wr_n [*4] ##1 o_wr_n)
    else $error("write low phase length");
  a_rd_low_phase: assert property ($fell(o_rd_n) |-> !o_rd_n [*4] ##1 o_rd_n)
    else $error("read low phase length");
  a_cs_setup: assert property ($fell(o_cs_n) |-> (o_wr_n && o_rd_n) [*4])
    else $error("strobe too soon after select");
  a_cs_high_pulse: assert property ($rose(o_cs_n) |-> o_cs_n [*4])
    else $error("select pulse too short");
  a_take_selects: assert property (o_cs_n && i_req_valid && o_req_ready |=> !o_cs_n)
    else $error("select not taken");
  a_rsp_single: assert property (o_rsp_valid |=> !o_rsp_valid)
    else $error("response longer than a cycle");

  c_read_bit: cover property ($fell(o_rd_n));
  c_chained: cover property (o_rsp_valid && !o_cs_n);
  c_deselect: cover property ($rose(o_cs_n));
endmodule : lscp_host_asserts

bind lscp_host lscp_host_asserts #(.PHASE_CYC(PHASE_CYC)) u_chk (
  .i_clk_sys, .i_rst_n, .i_req_valid, .o_req_ready, .o_rsp_valid,
  .o_cs_n, .o_wr_n, .o_rd_n, .o_data_out, .o_data_oe_n
);

`default_nettype wire

// >>> test/lscp_dev_model.sv
// behavioural model of the lcd controller serial port
`timescale 1ns/100ps
`default_nettype none

module lscp_dev_model (
  input  wire logic i_cs_n,
  input  wire logic i_wr_n,
  input  wire logic i_rd_n,
  input  wire logic i_data,
  output var  logic o_data,
  output var  logic o_data_oe_n
);
  logic [3:0] ram [64];
  logic [2:0] id;
  logic [5:0] adr;
  logic [8:0] sr, cmd;
  logic       system_enable_cmd, display_on_cmd, tb_en, wd_en, tone_on, bias3;
  logic [1:0] coms;
  int         n, k, nid, tb_clr, wd_clr;
  // irq source: 1 shows the watchdog flag, 0 the time base clock
  logic       irq_wd, wd_flag;
  localparam int LCD_DIV = 32768 / 256; // lcd clock divider from the crystal

  task automatic run_cmd;
    case (cmd[8:1])
      8'h00: {system_enable_cmd, display_on_cmd} = 2'h0;
      8'h01: system_enable_cmd = 1'b1;
      8'h02: display_on_cmd = 1'b0;
      8'h03: display_on_cmd = 1'b1;
      8'h04: tb_en = 1'b0;
      8'h06: {tb_en, irq_wd} = 2'h2;
      8'h05: wd_en = 1'b0;
      8'h07: {wd_en, irq_wd} = 2'h3;
      8'h08: tone_on = 1'b0;
      8'h0d: tb_clr++;
      8'h0e, 8'h0f:
      begin
        wd_clr++;
        wd_flag = 1'b0; // releases a held-low interrupt
      end
      default:
        if (cmd[8:5] == 4'h2)
        begin
          coms = cmd[4:3];
          bias3 = cmd[1];
        end
    endcase
  endtask : run_cmd

  initial
  begin
    {system_enable_cmd, display_on_cmd, tb_en, wd_en, tone_on} = '0;
    {irq_wd, wd_flag} = 2'h0;
    n = 0;
    k = 0;
    nid = 0;
    tb_clr = 0;
    wd_clr = 0;
    o_data = 1'b0;
    o_data_oe_n = 1'b1;
  end

  // select high wipes the mode; a fresh identifier must follow
  always @(posedge i_cs_n)
  begin
    n = 0;
    o_data_oe_n = 1'b1;
  end

  always @(negedge i_wr_n)
    o_data_oe_n = 1'b1;

  always @(negedge i_rd_n)
    if (!i_cs_n && n == 9 && k < 4)
    begin
      o_data = ram[adr][k];
      o_data_oe_n = 1'b0;
      k++;
    end

  always @(posedge i_wr_n)
    if (!i_cs_n)
    begin
      if (n < 3)
      begin
        id = {id[1:0], i_data};
        k = 0;
        n++;
        if (n == 3)
          nid++;
      end
      else if (id == 3'h4)
      begin
        sr = {sr[7:0], i_data};
        n++;
        if (n == 12)
        begin
          n = 3;
          cmd = sr;
          run_cmd();
        end
      end
      else if (n < 9)
      begin
        adr = {adr[4:0], i_data};
        n++;
      end
      else if (n < 13)
      begin
        ram[adr][n-9] = i_data;
        n++;
      end
    end
endmodule : lscp_dev_model

`default_nettype wire

// >>> test/test_lcd_serial_command_port.sv
// bench for the lcd serial command port controller
`timescale 1ns/100ps
`default_nettype none
`include "lscp_cfg.svh"

module test_lcd_serial_command_port;
  import lscp_pkg::*;
  logic       clk, rst_n, vld, chain, rdy, rv, cs_n, wr_n, rd_n, dq, oe_n;
  logic       dev_d, dev_oe_n;
  lscp_op_t   op;
  logic [5:0] adr;
  logic [3:0] dat, rsp, rd;
  logic [8:0] cmd;
  logic [8:0] codes [13];
  int         failures, tests_run, i;
  // released line floats up through the pull-up
  wire logic  line = !oe_n ? dq : (!dev_oe_n ? dev_d : 1'b1);

  lscp_host #(.PHASE_CYC(4)) u_dut (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_req_valid(vld), .i_req_op(op),
    .i_req_addr(adr), .i_req_data(dat), .i_req_cmd(cmd), .i_req_chain(chain),
    .o_req_ready(rdy), .o_rsp_valid(rv), .o_rsp_data(rsp), .o_cs_n(cs_n),
    .o_wr_n(wr_n), .o_rd_n(rd_n), .o_data_out(dq), .o_data_oe_n(oe_n),
    .i_data_in(line)
  );

  lscp_dev_model u_dev (
    .i_cs_n(cs_n), .i_wr_n(wr_n), .i_rd_n(rd_n), .i_data(line),
    .o_data(dev_d), .o_data_oe_n(dev_oe_n)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop;
    if (failures == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic req(input lscp_op_t o, input logic [5:0] a, input logic [3:0] d,
                     input logic [8:0] c, input logic ch);
    int t;
    for (t = 0; t < 400 && rdy !== 1'b1; t++)
      @(posedge clk) #1;
    if (rdy !== 1'b1)
    begin
      failures++;
      $display("CHECK FAILED %0t never ready", $time);
      report_and_stop();
    end
    op = o;
    adr = a;
    dat = d;
    cmd = c;
    chain = ch;
    vld = 1'b1;
    @(posedge clk) #1;
    vld = 1'b0;
    for (t = 0; t < 400 && rv !== 1'b1; t++)
      @(posedge clk) #1;
    if (rv !== 1'b1)
    begin
      failures++;
      $display("CHECK FAILED %0t no response", $time);
      report_and_stop();
    end
    rd = rsp;
  endtask : req

  initial
  begin
    failures = 0;
    tests_run = 0;
    {vld, chain, adr, dat, cmd} = '0;
    op = LSCP_OP_CMD;
    rst_n = 1'b0;
    codes = '{`LSCP_DISPLAY_OFF_CMD, `LSCP_TIMEBASE_DISABLE_CMD,
              `LSCP_WATCHDOG_DISABLE_CMD, `LSCP_SYSTEM_DISABLE_CMD,
              `LSCP_TONE_OFF_CMD, `LSCP_TIMEBASE_CLEAR_CMD, `LSCP_WATCHDOG_CLEAR_CMD,
              9'h01e, 9'h052, `LSCP_SYSTEM_ENABLE_CMD, `LSCP_DISPLAY_ON_CMD,
              `LSCP_TIMEBASE_ENABLE_CMD, `LSCP_WATCHDOG_ENABLE_CMD};
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    chk({cs_n, wr_n, rd_n, oe_n}, 4'hf);
    req(LSCP_OP_WRITE, 6'h3f, 4'ha, 9'h000, 1'b0);
    chk(u_dev.ram[63], 4'ha);
    req(LSCP_OP_WRITE, 6'h00, 4'h5, 9'h000, 1'b0);
    req(LSCP_OP_READ, 6'h3f, 4'h0, 9'h000, 1'b0);
    chk(rd, 4'ha);
    chk(u_dev.id, 3'h6);
    req(LSCP_OP_UPDATE, 6'h00, 4'h3, 9'h000, 1'b0);
    chk(rd, 4'h5);
    chk(u_dev.ram[0], 4'h3);
    chk(u_dev.id, 3'h5);
    // last three go out as one chained frame
    for (i = 0; i < 13; i++)
    begin
      req(LSCP_OP_CMD, 6'h00, 4'h0, codes[i], i == 10 || i == 11);
      chk(u_dev.cmd, codes[i]);
    end
    chk(u_dev.nid, 9'h00f);
    chk({u_dev.system_enable_cmd, u_dev.display_on_cmd, u_dev.tb_en, u_dev.wd_en}, 4'hf);
    chk(u_dev.irq_wd, 1'b1);
    chk({u_dev.coms, u_dev.bias3}, 3'h5);
    chk(u_dev.wd_clr, 9'h002);
    chk(u_dev.tb_clr, 9'h001);
    // a data frame breaking a chain must reselect first
    req(LSCP_OP_CMD, 6'h00, 4'h0, `LSCP_DISPLAY_OFF_CMD, 1'b1);
    req(LSCP_OP_WRITE, 6'h15, 4'h9, 9'h000, 1'b0);
    chk(u_dev.ram[21], 4'h9);
    chk(u_dev.nid, 9'h011);
    chk(u_dev.display_on_cmd, 1'b0);
    report_and_stop();
  end
endmodule : test_lcd_serial_command_port

`default_nettype wire
